// >>> ltr_pkg.sv
// Package: register map, field layout, reset values and modes of the threshold bank
package ltr_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          LUX_W           = 24;
    // Register addresses
    localparam logic [7:0]  ADDR_LOWER      = 8'h02;
    localparam logic [7:0]  ADDR_UPPER      = 8'h03;
    localparam logic [7:0]  ADDR_MAKER      = 8'h7e;
    localparam logic [7:0]  ADDR_PART       = 8'h7f;
    localparam logic [7:0]  ADDR_CTRL       = 8'h40;
    localparam logic [7:0]  ADDR_STATUS     = 8'h41;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h42;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h43;
    localparam logic [7:0]  ADDR_RESULT     = 8'h44;
    // Field positions of a threshold or result word
    localparam int          EXP_HI          = 15;
    localparam int          EXP_LO          = 12;
    localparam int          MAN_HI          = 11;
    localparam int          MAN_LO          = 0;
    // Reset values
    localparam logic [15:0] LOWER_RESET     = 16'h0000;
    localparam logic [15:0] UPPER_RESET     = 16'hbfff;
    localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    // Masking applies to range codes below this
    localparam logic [3:0]  RANGE_AUTO      = 4'hc;
    // Highest exponent code with a defined full scale
    localparam logic [3:0]  EXP_MAX         = 4'hb;
    // Control and status bit positions
    localparam int          CTRL_MASK_BIT   = 0;
    localparam int          IRQ_ABOVE_BIT   = 0;
    localparam int          IRQ_BELOW_BIT   = 1;
    // Memory of the register file
    localparam int          MEM_DEPTH       = 2;
    localparam int          MEM_AW          = 1;
    localparam logic [0:0]  MEM_LOWER       = 1'h0;
    localparam logic [0:0]  MEM_UPPER       = 1'h1;
    // Read-out selector states
    typedef enum logic [2:0] {
        LTR_RD_MEM  = 3'b001,
        LTR_RD_REG  = 3'b010,
        LTR_RD_ZERO = 3'b100
    } ltr_rd_src_t;
endpackage : ltr_pkg

// >>> ltr_limit_mem.sv
// Two-word threshold store with registered read data and written reset contents
module ltr_limit_mem #(
    parameter int          WIDTH = 16,
    parameter int          DEPTH = 2,
    parameter int          AW    = 1,
    parameter logic [15:0] INIT0 = 16'h0000,
    parameter logic [15:0] INIT1 = 16'hbfff
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data,
    output logic      [WIDTH-1:0] word0,
    output logic      [WIDTH-1:0] word1
);
    initial begin
        if (DEPTH != 2 || WIDTH != 16 || AW != 1) begin
            $error("ltr_limit_mem supports only two 16-bit words");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] w0;
        logic [WIDTH-1:0] w1;
        logic [WIDTH-1:0] rd;
    } ltr_mem_state_t;

    ltr_mem_state_t st_r;
    ltr_mem_state_t st_nxt;

    // Write port and registered read port
    always_comb begin
        st_nxt = st_r;
        if (wr_en && wr_addr == 1'b0) begin
            st_nxt.w0 = wr_data;
        end
        if (wr_en && wr_addr == 1'b1) begin
            st_nxt.w1 = wr_data;
        end
        st_nxt.rd = (rd_addr == 1'b0) ? st_r.w0 : st_r.w1;
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{w0: INIT0, w1: INIT1, rd: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rd;
    assign word0   = st_r.w0;
    assign word1   = st_r.w1;
endmodule // ltr_limit_mem

// >>> ltr_threshold_regs.sv
// Threshold and identification register bank with lux comparison and interrupt
//
// Summary of operation
// - Lower limit: exponent bits 15:12, mantissa bits 11:0, writable, reset zero.
// - A limit means 0.01 lux times two to the exponent times mantissa.
// - Exponents 0 to 11 double full scale, 40.95 up to 83865.60 lux.
// - Result and limits are compared as common lux values, exponents may differ.
// - Comparison uses true result exponent; masking affects only the reported result.
// - Upper limit sets the upper level for interrupt and the above flag.
// - Upper limit has the same exponent and mantissa layout as the lower.
// - Upper limit at address 03h, reset BFFFh.
// - Read-only maker code register at 7Eh.
// - Read-only part code register at 7Fh.
// - Lower limit at address 02h gives the lower level for interrupt and the below flag.
// - Masking with range below 1100b reports exponent zero; comparison unchanged.
//
// Design decision made here: the plain strobed port.
module ltr_threshold_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0042, // Arbitrary value
    parameter int          LUX_BITS   = 24
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Conversion engine side
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    input  wire logic [3:0]  range_code,
    // Comparison outputs
    output logic             above_flag,
    output logic             below_flag,
    output logic             irq
);
    initial begin
        if (LUX_BITS != ltr_pkg::LUX_W) begin
            $error("LUX_BITS must equal the 24-bit lux width");
        end
    end

    // Lux value in 0.01 lux units: mantissa shifted by exponent
    function automatic logic [23:0] to_lux(input logic [15:0] word);
        logic [3:0]  e;
        logic [23:0] m;
        e = word[ltr_pkg::EXP_HI:ltr_pkg::EXP_LO];
        m = {12'h000, word[ltr_pkg::MAN_HI:ltr_pkg::MAN_LO]};
        if (e > ltr_pkg::EXP_MAX) begin
            e = ltr_pkg::EXP_MAX; // Undefined codes saturate to top scale
        end
        to_lux = m << e;
    endfunction

    typedef struct packed {
        logic [15:0]         result;
        logic [1:0]          ctrl;
        logic                above;
        logic                below;
        logic [1:0]          irq_stat;
        logic [1:0]          irq_mask;
        ltr_pkg::ltr_rd_src_t rd_src;
        logic [15:0]         rd_reg;
    } ltr_state_t;

    ltr_state_t  st_r;
    ltr_state_t  st_nxt;
    logic        mem_wr;
    logic [0:0]  mem_waddr;
    logic [0:0]  mem_raddr;
    logic [15:0] mem_rdata;
    logic [15:0] lower_word;
    logic [15:0] upper_word;
    logic [23:0] res_lux;
    logic [23:0] low_lux;
    logic [23:0] up_lux;
    logic [15:0] shown_result;

    // Threshold writes decode
    assign mem_wr    = reg_wr && (reg_addr == ltr_pkg::ADDR_LOWER
                                  || reg_addr == ltr_pkg::ADDR_UPPER);
    assign mem_waddr = (reg_addr == ltr_pkg::ADDR_UPPER) ? ltr_pkg::MEM_UPPER
                                                         : ltr_pkg::MEM_LOWER;
    assign mem_raddr = (reg_addr == ltr_pkg::ADDR_UPPER) ? ltr_pkg::MEM_UPPER
                                                         : ltr_pkg::MEM_LOWER;

    ltr_limit_mem #(
        .WIDTH (ltr_pkg::DATA_W),
        .DEPTH (ltr_pkg::MEM_DEPTH),
        .AW    (ltr_pkg::MEM_AW),
        .INIT0 (ltr_pkg::LOWER_RESET),
        .INIT1 (ltr_pkg::UPPER_RESET)
    ) u_mem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (reg_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata),
        .word0   (lower_word),
        .word1   (upper_word)
    );

    // Common lux values from the true result exponent
    assign res_lux = to_lux(conv_result);
    assign low_lux = to_lux(lower_word);
    assign up_lux  = to_lux(upper_word);

    // Reported result with optional exponent masking
    always_comb begin
        shown_result = st_r.result;
        if (st_r.ctrl[ltr_pkg::CTRL_MASK_BIT] && range_code < ltr_pkg::RANGE_AUTO) begin
            shown_result[ltr_pkg::EXP_HI:ltr_pkg::EXP_LO] = 4'h0;
        end
    end

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        // Comparison on each finished conversion, using current limits
        if (conv_done) begin
            st_nxt.result = conv_result;
            st_nxt.above  = res_lux > up_lux;
            st_nxt.below  = res_lux < low_lux;
        end
        // Control register write
        if (reg_wr && reg_addr == ltr_pkg::ADDR_CTRL) begin
            st_nxt.ctrl = reg_wdata[1:0];
        end
        // Mask register write
        if (reg_wr && reg_addr == ltr_pkg::ADDR_IRQ_MASK) begin
            st_nxt.irq_mask = reg_wdata[1:0];
        end
        // Write one to clear, set wins
        if (reg_wr && reg_addr == ltr_pkg::ADDR_IRQ_STAT) begin
            st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[1:0];
        end
        if (conv_done && res_lux > up_lux) begin
            st_nxt.irq_stat[ltr_pkg::IRQ_ABOVE_BIT] = 1'b1;
        end
        if (conv_done && res_lux < low_lux) begin
            st_nxt.irq_stat[ltr_pkg::IRQ_BELOW_BIT] = 1'b1;
        end
        // Read source selection, data in the following cycle
        st_nxt.rd_src = ltr_pkg::LTR_RD_ZERO;
        st_nxt.rd_reg = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ltr_pkg::ADDR_LOWER, ltr_pkg::ADDR_UPPER: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_MEM;
                end
                ltr_pkg::ADDR_MAKER: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = MAKER_CODE;
                end
                ltr_pkg::ADDR_PART: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = PART_CODE;
                end
                ltr_pkg::ADDR_CTRL: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = {14'h0000, st_r.ctrl};
                end
                ltr_pkg::ADDR_STATUS: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = {14'h0000, st_r.below, st_r.above};
                end
                ltr_pkg::ADDR_IRQ_STAT: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = {14'h0000, st_r.irq_stat};
                end
                ltr_pkg::ADDR_IRQ_MASK: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = {14'h0000, st_r.irq_mask};
                end
                ltr_pkg::ADDR_RESULT: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_REG;
                    st_nxt.rd_reg = shown_result;
                end
                default: begin
                    st_nxt.rd_src = ltr_pkg::LTR_RD_ZERO; // Unmapped reads zero
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{result: 16'h0000, ctrl: ltr_pkg::CTRL_RESET,
                      above: 1'b0, below: 1'b0, irq_stat: 2'h0,
                      irq_mask: ltr_pkg::IRQ_MASK_RESET,
                      rd_src: ltr_pkg::LTR_RD_ZERO, rd_reg: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read data mux: memory word and register word both arrive registered
    always_comb begin
        unique case (st_r.rd_src)
            ltr_pkg::LTR_RD_MEM:  reg_rdata = mem_rdata;
            ltr_pkg::LTR_RD_REG:  reg_rdata = st_r.rd_reg;
            ltr_pkg::LTR_RD_ZERO: reg_rdata = 16'h0000;
            default:              reg_rdata = 16'h0000;
        endcase
    end

    // Flags and interrupt level
    assign above_flag = st_r.above;
    assign below_flag = st_r.below;
    assign irq        = |(st_r.irq_stat & st_r.irq_mask);
endmodule // ltr_threshold_regs

// >>> ltr_regs_checker.sv
// Port checker of the threshold register bank, bound to its top module
module ltr_regs_chk #(
    parameter logic [15:0] MAKER_CODE = 16'h00a5,
    parameter logic [15:0] PART_CODE  = 16'h0042
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        conv_done,
    input wire logic [15:0] conv_result,
    input wire logic        above_flag,
    input wire logic        below_flag,
    input wire logic        irq
);
    logic [15:0] lo_r;
    logic [15:0] hi_r;
    // Limits as the register port left them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lo_r <= ltr_pkg::LOWER_RESET;
            hi_r <= ltr_pkg::UPPER_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ltr_pkg::ADDR_LOWER) lo_r <= reg_wdata;
            if (reg_addr == ltr_pkg::ADDR_UPPER) hi_r <= reg_wdata;
        end
    end
    // Common scale; the 0.01 lux factor cancels
    function automatic logic [23:0] lux(input logic [15:0] w);
        return {12'h000, w[11:0]} << ((w[15:12] > 4'hb) ? 4'hb : w[15:12]);
    endfunction
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_maker_read: assert property (reg_rd && reg_addr == ltr_pkg::ADDR_MAKER
        |=> reg_rdata == MAKER_CODE) else $error("maker code read wrong");
    chk_part_read: assert property (reg_rd && reg_addr == ltr_pkg::ADDR_PART
        |=> reg_rdata == PART_CODE) else $error("part code read wrong");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    chk_upper_wrrd: assert property (reg_wr && reg_addr == ltr_pkg::ADDR_UPPER ##1
        reg_rd && reg_addr == ltr_pkg::ADDR_UPPER |=> reg_rdata == $past(reg_wdata, 2))
        else $error("upper limit readback wrong");
    chk_lower_wrrd: assert property (reg_wr && reg_addr == ltr_pkg::ADDR_LOWER ##1
        reg_rd && reg_addr == ltr_pkg::ADDR_LOWER |=> reg_rdata == $past(reg_wdata, 2))
        else $error("lower limit readback wrong");
    chk_above_cmp: assert property (conv_done
        |=> above_flag == (lux($past(conv_result)) > lux($past(hi_r))))
        else $error("above flag wrong");
    chk_below_cmp: assert property (conv_done
        |=> below_flag == (lux($past(conv_result)) < lux($past(lo_r))))
        else $error("below flag wrong");
    chk_flags_hold: assert property (!conv_done |=> $stable({above_flag, below_flag}))
        else $error("flags moved without conversion");
    chk_irq_cause: assert property ($rose(irq)
        |-> $past(conv_done) || $past(reg_wr && reg_addr == ltr_pkg::ADDR_IRQ_MASK))
        else $error("interrupt rose without cause");
    chk_irq_drop: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt fell without write");
    cov_above: cover property (conv_done ##1 above_flag);
    cov_below: cover property (conv_done ##1 below_flag);
    cov_irq: cover property ($rose(irq));
    cov_wrrd: cover property (reg_wr && reg_addr == ltr_pkg::ADDR_UPPER ##1
        reg_rd && reg_addr == ltr_pkg::ADDR_UPPER);
endmodule // ltr_regs_chk

bind ltr_threshold_regs ltr_regs_chk #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE))
    ltr_regs_chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_result(conv_result), .above_flag(above_flag),
    .below_flag(below_flag), .irq(irq));

// >>> ltr_host_model.sv
// Host model driving the register port of the threshold bank
module ltr_host_model (
    input  wire logic        clk_sys,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // One-cycle write; address and data inverted once released
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
        #1;
    endtask
    // Write then read of one address, strobes with no gap between them
    task automatic wrrd(input logic [7:0] a, input logic [15:0] v, output logic [15:0] r);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        reg_addr  <= ~a;
        #1;
        r = reg_rdata;
    endtask
    // One-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
    endtask
endmodule // ltr_host_model

// >>> ltr_threshold_regs_tb_top.sv
// Self-checking bench of the threshold register bank
module ltr_threshold_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER = 16'h005a; // Arbitrary value
    localparam logic [15:0] PART  = 16'h0c3e; // Arbitrary value
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        conv_done = 1'b0;
    logic [15:0] conv_result = 16'h0000;
    logic [3:0]  range_code = 4'h0;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic        reg_wr, reg_rd, above_flag, below_flag, irq;
    logic [15:0] lo = 16'h0000, hi = 16'hbfff;
    int          num_errors = 0, comparisons = 0, seed = 17;

    always #2.5 clk_sys = ~clk_sys;
    ltr_host_model ltr_host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ltr_threshold_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) ltr_threshold_regs_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_result(conv_result), .range_code(range_code), .above_flag(above_flag),
        .below_flag(below_flag), .irq(irq));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [23:0] lux(input logic [15:0] w);
        return {12'h000, w[11:0]} << ((w[15:12] > 4'hb) ? 4'hb : w[15:12]);
    endfunction
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        ltr_host_model_i.rd(a, d);
        check(nm, d, exp);
    endtask
    // Write and keep the bench's copy of the limits
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        ltr_host_model_i.wr(a, v);
        if (a == ltr_pkg::ADDR_LOWER) lo = v;
        if (a == ltr_pkg::ADDR_UPPER) hi = v;
    endtask
    // Write a limit and read it back in the very next cycle
    task automatic wr_rd_chk(input string nm, input logic [7:0] a, input logic [15:0] v);
        ltr_host_model_i.wrrd(a, v, d);
        if (a == ltr_pkg::ADDR_LOWER) lo = v;
        if (a == ltr_pkg::ADDR_UPPER) hi = v;
        check(nm, d, v);
    endtask
    // One conversion, then both flags against the common lux scale
    task automatic conv(input logic [15:0] res, input logic [3:0] rc);
        @(posedge clk_sys);
        conv_done   <= 1'b1;
        conv_result <= res;
        range_code  <= rc;
        @(posedge clk_sys);
        conv_done   <= 1'b0;
        conv_result <= ~res;
        #1;
        check("above", 16'(above_flag), 16'(lux(res) > lux(hi)));
        check("below", 16'(below_flag), 16'(lux(res) < lux(lo)));
    endtask
    task automatic finish_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values, read-only words, unmapped place
        rd_chk("lower", ltr_pkg::ADDR_LOWER, 16'h0000);
        rd_chk("upper", ltr_pkg::ADDR_UPPER, 16'hbfff);
        wr(ltr_pkg::ADDR_MAKER, 16'hffff);
        wr(ltr_pkg::ADDR_PART, 16'h0000);
        rd_chk("maker", ltr_pkg::ADDR_MAKER, MAKER);
        rd_chk("part", ltr_pkg::ADDR_PART, PART);
        rd_chk("unmapped", 8'h10, 16'h0000);
        // Equal lux with different exponents is neither above nor below, one more is above
        wr(ltr_pkg::ADDR_UPPER, 16'h1002);
        wr(ltr_pkg::ADDR_LOWER, 16'h0004);
        conv(16'h0004, 4'h0);
        conv(16'h0005, 4'h0);
        // Random limits, results and masking
        for (int i = 0; i < 240; i++) begin
            if (i % 4 == 0) wr(ltr_pkg::ADDR_LOWER, 16'($random(seed)));
            if (i % 4 == 1) wr(ltr_pkg::ADDR_UPPER, 16'($random(seed)));
            if (i % 8 == 2) rd_chk("upper", ltr_pkg::ADDR_UPPER, hi);
            if (i % 8 == 3) rd_chk("lower", ltr_pkg::ADDR_LOWER, lo);
            if (i % 16 == 5) wr(ltr_pkg::ADDR_CTRL, 16'(i[4]));
            if (i % 8 == 6) wr_rd_chk("upper wr", ltr_pkg::ADDR_UPPER, 16'($random(seed)));
            if (i % 8 == 7) wr_rd_chk("lower wr", ltr_pkg::ADDR_LOWER, 16'($random(seed)));
            conv(16'($random(seed)), 4'($random(seed)));
        end
        // Interrupt masked, unmasked, cleared
        wr(ltr_pkg::ADDR_CTRL, 16'h0000);
        wr(ltr_pkg::ADDR_UPPER, 16'h0010);
        wr(ltr_pkg::ADDR_LOWER, 16'h2100);
        wr(ltr_pkg::ADDR_IRQ_MASK, 16'h0000);
        wr(ltr_pkg::ADDR_IRQ_STAT, 16'h0003);
        conv(16'h0fff, 4'h0);
        check("irq masked", 16'(irq), 16'h0000);
        wr(ltr_pkg::ADDR_IRQ_MASK, 16'h0001);
        check("irq", 16'(irq), 16'h0001);
        rd_chk("status", ltr_pkg::ADDR_STATUS, 16'h0001);
        wr(ltr_pkg::ADDR_IRQ_STAT, 16'h0001);
        check("irq clear", 16'(irq), 16'h0000);
        wr(ltr_pkg::ADDR_IRQ_MASK, 16'h0002);
        conv(16'h0001, 4'h0);
        check("irq below", 16'(irq), 16'h0001);
        // Manual range with masking, range code in the limit exponent
        wr(ltr_pkg::ADDR_CTRL, 16'h0001);
        wr(ltr_pkg::ADDR_UPPER, 16'h5800);
        conv(16'h5900, 4'h5);
        rd_chk("masked", ltr_pkg::ADDR_RESULT, 16'h0900);
        conv(16'h5900, 4'hc);
        rd_chk("unmasked", ltr_pkg::ADDR_RESULT, 16'h5900);
        check("irq sticky", 16'(irq), 16'h0001);
        // Reset in mid-run: limits back to reset values, above flag and interrupt dropped
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("irq reset", 16'(irq), 16'h0000);
        check("above reset", 16'(above_flag), 16'h0000);
        reset_n <= 1'b1;
        lo = ltr_pkg::LOWER_RESET;
        hi = ltr_pkg::UPPER_RESET;
        rd_chk("upper reset", ltr_pkg::ADDR_UPPER, ltr_pkg::UPPER_RESET);
        rd_chk("lower reset", ltr_pkg::ADDR_LOWER, ltr_pkg::LOWER_RESET);
        conv(16'h0001, 4'h0);
        finish_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end
endmodule // ltr_threshold_regs_tb_top
